// *** core/swlb_params.svh ***
`ifndef SWLB_PARAMS_SVH
`define SWLB_PARAMS_SVH

// serial word layout
`define SWLB_WORD_BITS 11
`define SWLB_ADDR_MSB 10
`define SWLB_ADDR_LSB 8
`define SWLB_CODE_MSB 7
`define SWLB_CODE_LSB 0

// channel and code figures
`define SWLB_CHAN_MAX 6
`define SWLB_CHAN_FOUR 3'h4
`define SWLB_CHAN_SIX 3'h6
`define SWLB_CODE_BITS 8
`define SWLB_TAPS 256
`define SWLB_MIDSCALE 8'h80

// reset values of idle pins and of the chain latch
`define SWLB_PIN_IDLE 1'b1
`define SWLB_CHAIN_CLR 1'b0

`endif

// *** core/swlb_pkg.sv ***
`include "swlb_params.svh"
`default_nettype none
package swlb_pkg;

    typedef enum logic {
        SWLB_VAR_FOUR = 1'b0,
        SWLB_VAR_SIX = 1'b1
    } swlb_variant_e;

    typedef logic [`SWLB_CODE_BITS-1:0] swlb_code_t;
    typedef logic [2:0] swlb_addr_t;

    // true when the address names a channel fitted on this variant
    function automatic logic swlb_chan_present(input swlb_addr_t addr,
                                               input swlb_variant_e var_sel);
        logic ok;
        ok = 1'b0;
        if (var_sel == SWLB_VAR_SIX) begin
            ok = (addr < `SWLB_CHAN_SIX);
        end else begin
            ok = (addr < `SWLB_CHAN_FOUR);
        end
        return ok;
    endfunction

    // one-of-256 tap selection from a latch code
    function automatic logic [`SWLB_TAPS-1:0] swlb_tap_decode(
            input swlb_code_t code);
        logic [`SWLB_TAPS-1:0] sel;
        sel = '0;
        sel[code] = 1'b1;
        return sel;
    endfunction

    typedef struct packed {
        logic [1:0] cs_n;
        logic [1:0] sclk;
        logic [1:0] sin;
        logic [1:0] preset_n;
        logic [1:0] pdown_n;
        logic sclk_prev;
        logic cs_n_prev;
        logic [`SWLB_WORD_BITS-1:0] shift;
        logic chain;
        logic chain_oe;
        logic load;
        swlb_addr_t load_sel;
        swlb_code_t load_code;
    } swlb_front_s;

    typedef struct packed {
        logic [`SWLB_CHAN_MAX-1:0][`SWLB_CODE_BITS-1:0] pos;
    } swlb_bank_s;

endpackage
`default_nettype wire

// *** core/swlb_bank_if.sv ***
`include "swlb_params.svh"
`default_nettype none
interface swlb_bank_if;
    import swlb_pkg::*;

    logic load;
    swlb_addr_t sel;
    swlb_code_t code;
    logic preset;
    logic [`SWLB_CHAN_MAX-1:0][`SWLB_CODE_BITS-1:0] pos;

    modport ctrl (
        output load,
        output sel,
        output code,
        output preset,
        input pos
    );

    modport bank (
        input load,
        input sel,
        input code,
        input preset,
        output pos
    );

endinterface
`default_nettype wire

// *** core/swlb_latch_bank.sv ***
`include "swlb_params.svh"
`default_nettype none
module swlb_latch_bank
    import swlb_pkg::*;
(
    // clock and reset
    input wire logic core_clk_i,
    input wire logic nrst_i,
    input wire logic clk_en_i,
    // latch access
    swlb_bank_if.bank bank
);

    swlb_bank_s st_q;
    swlb_bank_s st_d;

    always_comb begin
        st_d = st_q;
        if (bank.preset) begin
            for (int i = 0; i < `SWLB_CHAN_MAX; i++) begin
                st_d.pos[i] = `SWLB_MIDSCALE;
            end
        end else if (bank.load && (bank.sel < `SWLB_CHAN_SIX)) begin
            st_d.pos[bank.sel] = bank.code;
        end
    end

    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            for (int i = 0; i < `SWLB_CHAN_MAX; i++) begin
                st_q.pos[i] <= `SWLB_MIDSCALE;
            end
        end else if (clk_en_i) begin
            st_q <= st_d;
        end
    end

    assign bank.pos = st_q.pos;

endmodule
`default_nettype wire

// *** core/swlb_top.sv ***
`include "swlb_params.svh"
`default_nettype none
module swlb_top
    import swlb_pkg::*;
(
    // clock, reset, enable
    input wire logic core_clk_i,
    input wire logic nrst_i,
    input wire logic clk_en_i,
    // variant select, same clock domain
    input wire logic variant_six_i,
    // serial write pins
    input wire logic cs_n_i,
    input wire logic sclk_i,
    input wire logic serial_in_i,
    // control pins
    input wire logic preset_midscale_n_i,
    input wire logic power_down_n_i,
    // chain output, open drain
    output logic chain_out_o,
    output logic chain_out_oe_o,
    // latch contents, channel n at bits 8n+7..8n
    output logic [`SWLB_CHAN_MAX*`SWLB_CODE_BITS-1:0] position_o,
    // tap selection, channel n at bits 256n+255..256n
    output logic [`SWLB_CHAN_MAX*`SWLB_TAPS-1:0] wiper_tap_sel_o,
    // terminal switches per channel
    output logic [`SWLB_CHAN_MAX-1:0] terminal_high_en_o,
    output logic [`SWLB_CHAN_MAX-1:0] wiper_to_low_o
);

    swlb_front_s st_q;
    swlb_front_s st_d;
    swlb_variant_e var_sel;
    logic cs_n_s;
    logic sclk_s;
    logic sin_s;
    logic sclk_rise;
    logic cs_rise;
    logic preset_act;
    logic pdown_act;
    logic chain_en;

    swlb_bank_if bank_if ();

    // variant and synchronised pin levels
    always_comb begin
        var_sel = variant_six_i ? SWLB_VAR_SIX : SWLB_VAR_FOUR;
        cs_n_s = st_q.cs_n[1];
        sclk_s = st_q.sclk[1];
        sin_s = st_q.sin[1];
    end

    // edge detection on second sync stage only
    always_comb begin
        sclk_rise = sclk_s & ~st_q.sclk_prev;
        cs_rise = cs_n_s & ~st_q.cs_n_prev;
    end

    // preset and shutdown exist on the four-channel variant
    always_comb begin
        preset_act = ~st_q.preset_n[1] & (var_sel == SWLB_VAR_FOUR);
        pdown_act = ~st_q.pdown_n[1] & (var_sel == SWLB_VAR_FOUR);
    end

    // chain output driven only while selected and not shut down
    always_comb begin
        chain_en = ~cs_n_s & ~pdown_act;
    end

    always_comb begin
        st_d = st_q;

        // two-stage pin synchronisers
        st_d.cs_n = {st_q.cs_n[0], cs_n_i};
        st_d.sclk = {st_q.sclk[0], sclk_i};
        st_d.sin = {st_q.sin[0], serial_in_i};
        st_d.preset_n = {st_q.preset_n[0], preset_midscale_n_i};
        st_d.pdown_n = {st_q.pdown_n[0], power_down_n_i};

        // edge history
        st_d.sclk_prev = sclk_s;
        st_d.cs_n_prev = cs_n_s;

        // serial shift, first bit ends at the top
        if (sclk_rise && !cs_n_s) begin
            st_d.chain = st_q.shift[`SWLB_WORD_BITS-1];
            st_d.shift = {st_q.shift[`SWLB_WORD_BITS-2:0], sin_s};
        end

        // load strobe on chip select rising
        st_d.load = 1'b0;
        if (cs_rise && !preset_act) begin
            st_d.load_sel = st_q.shift[`SWLB_ADDR_MSB:`SWLB_ADDR_LSB];
            st_d.load_code = st_q.shift[`SWLB_CODE_MSB:`SWLB_CODE_LSB];
            st_d.load = swlb_chan_present(
                st_q.shift[`SWLB_ADDR_MSB:`SWLB_ADDR_LSB],
                var_sel);
        end

        // preset clears the chain latch and blocks loads
        if (preset_act) begin
            st_d.chain = `SWLB_CHAIN_CLR;
            st_d.load = 1'b0;
        end

        // open drain: enable pulls the pin low for a zero
        st_d.chain_oe = chain_en & ~st_d.chain;
    end

    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            st_q.cs_n <= {2{`SWLB_PIN_IDLE}};
            st_q.sclk <= 2'h0;
            st_q.sin <= 2'h0;
            st_q.preset_n <= {2{`SWLB_PIN_IDLE}};
            st_q.pdown_n <= {2{`SWLB_PIN_IDLE}};
            st_q.sclk_prev <= 1'b0;
            st_q.cs_n_prev <= `SWLB_PIN_IDLE;
            st_q.shift <= '0;
            st_q.chain <= `SWLB_CHAIN_CLR;
            st_q.chain_oe <= 1'b0;
            st_q.load <= 1'b0;
            st_q.load_sel <= 3'h0;
            st_q.load_code <= 8'h00;
        end else if (clk_en_i) begin
            st_q <= st_d;
        end
    end

    // latch bank requests
    assign bank_if.load = st_q.load;
    assign bank_if.sel = st_q.load_sel;
    assign bank_if.code = st_q.load_code;
    assign bank_if.preset = preset_act;

    swlb_latch_bank u_bank (
        .core_clk_i(core_clk_i),
        .nrst_i(nrst_i),
        .clk_en_i(clk_en_i),
        .bank(bank_if.bank)
    );

    // chain pin
    assign chain_out_o = 1'b0;
    assign chain_out_oe_o = st_q.chain_oe;

    // latch contents and tap network per channel
    always_comb begin
        position_o = '0;
        wiper_tap_sel_o = '0;
        terminal_high_en_o = '0;
        wiper_to_low_o = '0;
        for (int i = 0; i < `SWLB_CHAN_MAX; i++) begin
            position_o[i*`SWLB_CODE_BITS +: `SWLB_CODE_BITS] =
                bank_if.pos[i];
            // tap k is k steps above B, top tap sits below A
            wiper_tap_sel_o[i*`SWLB_TAPS +: `SWLB_TAPS] =
                swlb_tap_decode(bank_if.pos[i]);
            if (swlb_chan_present(3'(i), var_sel)) begin
                terminal_high_en_o[i] = ~pdown_act;
                wiper_to_low_o[i] = pdown_act;
            end
        end
    end

endmodule
`default_nettype wire

// *** sim/swlb_host_model.sv ***
`default_nettype none
module swlb_host_model (
    // clock
    input wire logic core_clk_i,
    // serial write pins
    output logic cs_n_o,
    output logic sclk_o,
    output logic serial_in_o
);
    timeunit 1ns;
    timeprecision 1ns;

    initial begin
        cs_n_o = 1'b1;
        sclk_o = 1'b0;
        serial_in_o = 1'b0;
    end

    // one whole word, h core cycles per clock phase
    task automatic send(input logic [10:0] w, input int h);
        cs_n_o = 1'b0;
        for (int i = 10; i >= 0; i--) begin
            serial_in_o = w[i];
            repeat (h) @(negedge core_clk_i);
            sclk_o = 1'b1;
            repeat (h) @(negedge core_clk_i);
            sclk_o = 1'b0;
        end
        repeat (h) @(negedge core_clk_i);
        cs_n_o = 1'b1;
        serial_in_o = ~serial_in_o;
        // deselect stands long enough for the block to see it
        repeat (h) @(negedge core_clk_i);
    endtask
endmodule
`default_nettype wire

// *** sim/swlb_top_assertions.sv ***
`default_nettype none
module swlb_top_assertions
    import swlb_pkg::*;
(
    // clock and reset
    input wire logic core_clk_i,
    input wire logic nrst_i,
    // pins
    input wire logic variant_six_i,
    input wire logic cs_n_i,
    input wire logic preset_midscale_n_i,
    input wire logic power_down_n_i,
    // outputs
    input wire logic chain_out_oe_o,
    input wire logic [47:0] position_o,
    input wire logic [1535:0] wiper_tap_sel_o,
    input wire logic [5:0] terminal_high_en_o,
    input wire logic [5:0] wiper_to_low_o
);
    localparam logic [47:0] MID = {6{8'h80}};
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!nrst_i);

    a_tap_low:
    assert property (wiper_tap_sel_o[255:0] == 256'h1 << position_o[7:0])
        else $error("tap select wrong on channel 0");
    a_tap_top:
    assert property (wiper_tap_sel_o[1535:1280] ==
        256'h1 << position_o[47:40])
        else $error("tap select wrong on channel 5");
    a_reset_mid:
    assert property ($rose(nrst_i) |-> position_o == MID)
        else $error("latches not midscale after reset");
    a_preset_mid:
    assert property ((!variant_six_i && !preset_midscale_n_i) [*4]
        |-> position_o == MID)
        else $error("preset did not force midscale");
    a_hold_idle:
    assert property ((cs_n_i && preset_midscale_n_i) [*8]
        |-> $stable(position_o))
        else $error("latch changed without a load");
    a_four_upper:
    assert property (!variant_six_i && $stable(variant_six_i)
        |-> $stable(position_o[47:32]))
        else $error("absent channel changed");
    a_power_down_n_open:
    assert property ((!variant_six_i && !power_down_n_i) [*3]
        |-> terminal_high_en_o[3:0] == 4'h0 &&
        wiper_to_low_o[3:0] == 4'hf && !chain_out_oe_o)
        else $error("shutdown switches wrong");
    a_power_down_n_run:
    assert property ((!variant_six_i && power_down_n_i) [*3]
        |-> terminal_high_en_o[3:0] == 4'hf &&
        wiper_to_low_o[3:0] == 4'h0)
        else $error("run switches wrong");
    a_chain_idle:
    assert property (cs_n_i [*4] |-> !chain_out_oe_o)
        else $error("chain output driven while deselected");
endmodule
bind swlb_top swlb_top_assertions chk (
    .core_clk_i(core_clk_i),
    .nrst_i(nrst_i),
    .variant_six_i(variant_six_i),
    .cs_n_i(cs_n_i),
    .preset_midscale_n_i(preset_midscale_n_i),
    .power_down_n_i(power_down_n_i),
    .chain_out_oe_o(chain_out_oe_o),
    .position_o(position_o),
    .wiper_tap_sel_o(wiper_tap_sel_o),
    .terminal_high_en_o(terminal_high_en_o),
    .wiper_to_low_o(wiper_to_low_o)
);
`default_nettype wire

// *** sim/swlb_top_test.sv ***
`default_nettype none
module swlb_top_test
    import swlb_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [47:0] MID = {6{8'h80}};
    logic core_clk_i, nrst_i, variant_six_i, preset_n, pdown_n;
    logic cs_n, sclk, serial_in, clk_en, chain_oe;
    logic [47:0] position, expv, last;
    logic [1535:0] tap;
    logic [5:0] hi_en, to_low;
    logic [47:0] expq[$];
    logic [2:0] a;
    int fail_count, tests_run;

    swlb_host_model host (.core_clk_i(core_clk_i), .cs_n_o(cs_n),
        .sclk_o(sclk), .serial_in_o(serial_in));
    swlb_top uut (.core_clk_i(core_clk_i), .nrst_i(nrst_i),
        .clk_en_i(clk_en), .variant_six_i(variant_six_i), .cs_n_i(cs_n),
        .sclk_i(sclk), .serial_in_i(serial_in), .preset_midscale_n_i(preset_n),
        .power_down_n_i(pdown_n), .chain_out_o(), .chain_out_oe_o(chain_oe),
        .position_o(position), .wiper_tap_sel_o(tap),
        .terminal_high_en_o(hi_en), .wiper_to_low_o(to_low));

    initial begin
        core_clk_i = 1'b0;
        forever #25 core_clk_i = ~core_clk_i;
    end

    task complete_run;
        if (fail_count == 0 && tests_run > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic chk(input logic [255:0] got, input logic [255:0] exp);
        tests_run++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task settle;
        for (int i = 0; i < 20 && expq.size() > 0; i++)
            @(negedge core_clk_i);
        if (expq.size() > 0) begin
            fail_count++;
            complete_run;
        end
    endtask

    // the note is queued before the word goes out, so it is there in time
    task automatic wr(input logic [2:0] ad, input logic [7:0] c, input int h);
        logic [47:0] n;
        n = expv;
        if (ad < (variant_six_i ? 3'h6 : 3'h4)) begin
            n[8*ad +: 8] = c;
        end
        if (n !== expv) begin
            expq.push_back(n);
        end
        expv = n;
        host.send({ad, c}, h);
        settle;
    endtask

    // every latch change must match the oldest note
    always @(negedge core_clk_i) begin
        if (nrst_i && position !== last) begin
            if (expq.size() == 0) chk(position, last);
            else chk(position, expq.pop_front());
            last = position;
        end
    end

    initial begin
        nrst_i = 1'b0;
        variant_six_i = 1'b0;
        preset_n = 1'b1;
        pdown_n = 1'b1;
        clk_en = 1'b1;
        expv = MID;
        last = MID;
        fail_count = 0;
        tests_run = 0;
        void'($urandom(45129));
        repeat (2) @(negedge core_clk_i);
        nrst_i = 1'b1;
        chk(position, MID);
        chk(tap[255:0], 256'h1 << 8'h80);
        wr(3'h0, 8'h00, 4);
        chk(tap[255:0], 256'h1);
        wr(3'h0, 8'hff, 4);
        chk(tap[255:0], 256'h1 << 8'hff);
        for (int k = 0; k < 14; k++) begin
            a = 3'($urandom);
            wr(a, 8'($urandom), 4);
            if (a < 3'h4) begin
                chk(tap[256*a +: 256], 256'h1 << expv[8*a +: 8]);
            end
        end
        // code one selects tap one, one step above B
        wr(3'h3, 8'h01, 4);
        chk(tap[1023:768], 256'h2);
        preset_n = 1'b0;
        if (expv !== MID) expq.push_back(MID);
        expv = MID;
        host.send({3'h1, 8'h55}, 4);
        repeat (8) @(negedge core_clk_i);
        preset_n = 1'b1;
        settle;
        // chain cleared by preset pulls low, then shows the old word's lsb
        fork
            wr(3'h2, 8'h3c, 4);
            begin
                repeat (3) @(negedge core_clk_i);
                chk(chain_oe, 1'b1);
                repeat (87) @(negedge core_clk_i);
                chk(chain_oe, 1'b0);
            end
        join
        pdown_n = 1'b0;
        repeat (4) @(negedge core_clk_i);
        chk(hi_en[3:0], 4'h0);
        chk(to_low[3:0], 4'hf);
        pdown_n = 1'b1;
        repeat (4) @(negedge core_clk_i);
        chk(position, expv);
        chk(hi_en[3:0], 4'hf);
        // a word sent while the enable is low must be lost
        clk_en = 1'b0;
        host.send({3'h3, 8'h77}, 4);
        clk_en = 1'b1;
        repeat (6) @(negedge core_clk_i);
        chk(position, expv);
        variant_six_i = 1'b1;
        wr(3'h4, 8'ha5, 4);
        wr(3'h5, 8'h5a, 4);
        wr(3'h7, 8'h11, 4);
        chk(position, expv);
        complete_run;
    end
endmodule
`default_nettype wire
